// >>> common/tsc_pkg.sv
// Shared constants and types for the thermal sensor control block
package tsc_pkg;

  // Register indices on the serial register port
  localparam logic [2:0] TSC_IDX_FEAT = 3'h0;
  localparam logic [2:0] TSC_IDX_CTRL = 3'h1;
  localparam logic [2:0] TSC_IDX_HIGH = 3'h2;
  localparam logic [2:0] TSC_IDX_LOW = 3'h3;
  localparam logic [2:0] TSC_IDX_CRIT = 3'h4;
  localparam logic [2:0] TSC_IDX_TEMP = 3'h5;
  localparam logic [2:0] TSC_IDX_MFR = 3'h6;
  localparam logic [2:0] TSC_IDX_DEV = 3'h7;

  // Control register fields
  localparam int TSC_CTL_MODE = 0;
  localparam int TSC_CTL_POL = 1;
  localparam int TSC_CTL_CRIT_ONLY = 2;
  localparam int TSC_CTL_OUT_EN = 3;
  localparam int TSC_CTL_STATUS = 4;
  localparam int TSC_CTL_CLEAR = 5;
  localparam int TSC_CTL_ALARM_LOCK = 6;
  localparam int TSC_CTL_CRIT_LOCK = 7;
  localparam int TSC_CTL_HALT = 8;
  localparam int TSC_CTL_HYSTERESIS_SELECT_LO = 9;
  localparam int TSC_CTL_HYSTERESIS_SELECT_HI = 10;

  // Power-on values of writable registers
  localparam logic [15:0] TSC_RESET_VALUE = 16'h0000;
  // Limit registers keep bits 12..2 only
  localparam logic [15:0] TSC_LIMIT_MASK = 16'h1ffc;
  localparam int TSC_TEMP_W = 13;

  // Hysteresis codes and their size in 0.0625 degree steps
  localparam logic [1:0] TSC_HYSTERESIS_SELECT_OFF = 2'h0;
  localparam logic [1:0] TSC_HYSTERESIS_SELECT_1P5 = 2'h1;
  localparam logic [1:0] TSC_HYSTERESIS_SELECT_3P0 = 2'h2;
  localparam logic [1:0] TSC_HYSTERESIS_SELECT_6P0 = 2'h3;
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_STEPS_1P5 = 14'h0018;
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_STEPS_3P0 = 14'h0030;
  localparam logic [13:0] TSC_HYSTERESIS_SELECT_STEPS_6P0 = 14'h0060;

  // Resolution codes
  localparam logic [1:0] TSC_RES_0P5 = 2'h0;
  localparam logic [1:0] TSC_RES_0P25 = 2'h1;
  localparam logic [1:0] TSC_RES_0P125 = 2'h2;
  localparam logic [1:0] TSC_RES_0P0625 = 2'h3;

  // One register access from the serial engine
  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } tsc_req_t;

  typedef enum logic [0:0] {
    TSC_LNK_IDLE = 1'b0,
    TSC_LNK_WAIT = 1'b1
  } tsc_lnk_state_t;

endpackage : tsc_pkg

// >>> rtl/tsc_toggle_sync.sv
// Toggle event synchroniser: two flops, then edge detect into a pulse
`timescale 1ns/1ps
module tsc_toggle_sync (
  // Destination clock
  input wire logic clk,
  input wire logic rstn,
  // Source toggle, foreign domain
  input wire logic tog_in,
  // One-cycle event in destination domain
  output logic pulse
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      pulse <= 1'b0;
    end else begin
      meta <= tog_in;
      sync <= meta;
      last <= sync;
      pulse <= sync ^ last;
    end
  end
endmodule : tsc_toggle_sync

// >>> rtl/tsc_ctrl.sv
// Thermal sensor control, limit and alert logic behind the register port
// Functional notes
// - Reserved upper bits of feature and control registers ignore writes, read zero.
// - Shutdown flag: 0 freezes alert status on halt, 1 clears it.
// - Feature flag advertises a 25 to 35 ms bus time-out.
// - Two-bit resolution code: 0.5, 0.25, 0.125 or 0.0625 degree steps.
// - Flags advertise negative readings, accuracy class and interrupt support.
// - While halted, clear bit may clear alert status but never set it.
// - Hysteresis code selects off, 1.5, 3 or 6 degrees.
// - Halt stops conversion and freezes the reading at its last value.
// - Halt cannot be set while a lock is set; clearing always works.
// - Critical lock blocks critical limit writes until power-on reset.
// - Alarm lock blocks high and low limit writes until power-on reset.
// - Clear bit reads zero; clears latched event in interrupt mode only.
// - Above the critical limit, clear is held pending until the critical trip releases.
// - Status bit mirrors asserted alert, polarity independent, gated by enable.
// - Disabled output is inactive: released if active low, grounded if active high.
// - Hysteresis, enable, polarity and mode are frozen while any lock is set.
// - Critical-only selects critical crossings; cannot be set under alarm lock.
// - Polarity bit: 0 active low, 1 active high; mode: 0 comparator, 1 interrupt.
// - Limits are two's complement, bits 15..13 and 1..0 read zero.
// - Interrupt mode latches alert on each window crossing until cleared.
// - Comparator asserts outside window; critical-only asserts above critical only.
// - Limit updates re-evaluate the alert at once, not at next sample.
`timescale 1ns/1ps
module tsc_ctrl #(
  parameter logic SENSOR_HALT_CLEARS_ALERT = 1'b0,
  parameter logic BUS_TIMEOUT_SUPPORTED = 1'b1,
  parameter logic FEATURE_BIT5 = 1'b1,
  parameter logic [1:0] RESOLUTION_CODE = tsc_pkg::TSC_RES_0P125,
  parameter logic NEGATIVE_SUPPORTED = 1'b1,
  parameter logic ACCURACY_CLASS = 1'b1,
  parameter logic INTERRUPT_SUPPORTED = 1'b1,
  // Arbitrary identity values
  parameter logic [15:0] MFR_ID = 16'h00a5,
  parameter logic [15:0] DEV_ID = 16'h0100
) (
  // Core clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // Register port from the serial engine, link clock domain
  input wire logic link_clk,
  input wire logic lnk_req,
  input wire tsc_pkg::tsc_req_t lnk_cmd,
  output logic lnk_busy,
  output logic lnk_done,
  output logic [15:0] lnk_rdata,
  // Converter, core clock domain
  input wire logic temp_valid,
  input wire logic [tsc_pkg::TSC_TEMP_W-1:0] temp_sample,
  output logic conv_run,
  // Open-drain alert pin
  output logic alert_out,
  output logic alert_oe
);
  import tsc_pkg::*;

  // Link domain
  tsc_lnk_state_t lnk_state;
  tsc_req_t hold;
  logic req_tog;
  logic ack_pulse_l;
  // Core domain
  logic req_pulse;
  logic ack_tog;
  logic [15:0] core_rdata;
  // Control register fields
  logic [1:0] hysteresis_select;
  logic sensor_halt;
  logic crit_limit_write_lock;
  logic alarm_lock;
  logic out_en;
  logic critical_only_select;
  logic alert_polarity;
  logic int_mode;
  logic alert_pin_status;
  // Limits and reading
  logic [15:0] upper_alarm_threshold;
  logic [15:0] lower_alarm_threshold;
  logic [15:0] critical_threshold;
  logic [TSC_TEMP_W-1:0] thermal_unit;
  // Trip and event state
  logic hi_trip;
  logic lo_trip;
  logic crit_trip;
  logic event_latch;
  logic clear_pending;
  logic event_active;
  logic next_hi;
  logic next_lo;
  logic next_crit;
  logic next_event;
  logic next_status;
  logic [13:0] hysteresis_select_steps;
  logic signed [13:0] t14;
  logic signed [13:0] hi14;
  logic signed [13:0] lo14;
  logic signed [13:0] cr14;
  logic any_lock;
  logic wr_ctrl;
  logic wr_high;
  logic wr_low;
  logic wr_crit;
  logic clear_req;
  logic crossing;
  logic [15:0] feature_flags;
  logic [15:0] ctrl_read;
  logic [15:0] next_rdata;

  // Link side: one access at a time, fields held until answered
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lnk_state <= TSC_LNK_IDLE;
      hold <= '0;
      req_tog <= 1'b0;
      lnk_busy <= 1'b0;
      lnk_done <= 1'b0;
      lnk_rdata <= TSC_RESET_VALUE;
    end else begin
      lnk_done <= 1'b0;
      case (lnk_state)
        TSC_LNK_IDLE: begin
          if (lnk_req) begin
            hold <= lnk_cmd;
            req_tog <= ~req_tog;
            lnk_busy <= 1'b1;
            lnk_state <= TSC_LNK_WAIT;
          end
        end
        TSC_LNK_WAIT: begin
          // Core answer is stable once its toggle has crossed
          if (ack_pulse_l) begin
            lnk_rdata <= core_rdata;
            lnk_done <= 1'b1;
            lnk_busy <= 1'b0;
            lnk_state <= TSC_LNK_IDLE;
          end
        end
        default: begin
          lnk_state <= TSC_LNK_IDLE;
        end
      endcase
    end
  end

  tsc_toggle_sync u_req_sync (
    .clk(clk),
    .rstn(rstn),
    .tog_in(req_tog),
    .pulse(req_pulse)
  );

  tsc_toggle_sync u_ack_sync (
    .clk(link_clk),
    .rstn(rstn),
    .tog_in(ack_tog),
    .pulse(ack_pulse_l)
  );

  // Decode of one accepted access; hold is quiet while the toggle crosses
  always_comb begin
    any_lock = crit_limit_write_lock | alarm_lock;
    wr_ctrl = req_pulse & hold.wr & (hold.addr == TSC_IDX_CTRL);
    wr_high = req_pulse & hold.wr & (hold.addr == TSC_IDX_HIGH);
    wr_low = req_pulse & hold.wr & (hold.addr == TSC_IDX_LOW);
    wr_crit = req_pulse & hold.wr & (hold.addr == TSC_IDX_CRIT);
    clear_req = wr_ctrl & hold.wdata[TSC_CTL_CLEAR];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_tog <= 1'b0;
      core_rdata <= TSC_RESET_VALUE;
    end else if (req_pulse) begin
      ack_tog <= ~ack_tog;
      core_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hysteresis_select <= TSC_HYSTERESIS_SELECT_OFF;
      out_en <= 1'b0;
      alert_polarity <= 1'b0;
      int_mode <= 1'b0;
    end else if (wr_ctrl && !any_lock) begin
      hysteresis_select <= hold.wdata[TSC_CTL_HYSTERESIS_SELECT_HI:TSC_CTL_HYSTERESIS_SELECT_LO];
      out_en <= hold.wdata[TSC_CTL_OUT_EN];
      alert_polarity <= hold.wdata[TSC_CTL_POL];
      int_mode <= hold.wdata[TSC_CTL_MODE];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sensor_halt <= 1'b0;
    end else if (wr_ctrl) begin
      if (!hold.wdata[TSC_CTL_HALT]) begin
        sensor_halt <= 1'b0;
      end else if (!any_lock) begin
        sensor_halt <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crit_limit_write_lock <= 1'b0;
      alarm_lock <= 1'b0;
    end else if (wr_ctrl) begin
      crit_limit_write_lock <= crit_limit_write_lock | hold.wdata[TSC_CTL_CRIT_LOCK];
      alarm_lock <= alarm_lock | hold.wdata[TSC_CTL_ALARM_LOCK];
    end
  end

  // Critical-only not settable under alarm lock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      critical_only_select <= 1'b0;
    end else if (wr_ctrl) begin
      if (!alarm_lock || !hold.wdata[TSC_CTL_CRIT_ONLY]) begin
        critical_only_select <= hold.wdata[TSC_CTL_CRIT_ONLY];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upper_alarm_threshold <= TSC_RESET_VALUE;
      lower_alarm_threshold <= TSC_RESET_VALUE;
    end else begin
      // Limit bits outside 12..2 kept zero
      if (wr_high && !alarm_lock) begin
        upper_alarm_threshold <= hold.wdata & TSC_LIMIT_MASK;
      end
      if (wr_low && !alarm_lock) begin
        lower_alarm_threshold <= hold.wdata & TSC_LIMIT_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      critical_threshold <= TSC_RESET_VALUE;
    end else if (wr_crit && !crit_limit_write_lock) begin
      critical_threshold <= hold.wdata & TSC_LIMIT_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      thermal_unit <= '0;
      conv_run <= 1'b1;
    end else begin
      conv_run <= ~sensor_halt;
      if (temp_valid && !sensor_halt) begin
        thermal_unit <= temp_sample;
      end
    end
  end

  always_comb begin
    case (hysteresis_select)
      TSC_HYSTERESIS_SELECT_1P5: hysteresis_select_steps = TSC_HYSTERESIS_SELECT_STEPS_1P5;
      TSC_HYSTERESIS_SELECT_3P0: hysteresis_select_steps = TSC_HYSTERESIS_SELECT_STEPS_3P0;
      TSC_HYSTERESIS_SELECT_6P0: hysteresis_select_steps = TSC_HYSTERESIS_SELECT_STEPS_6P0;
      default: hysteresis_select_steps = '0;
    endcase
  end

  // Widened by one bit so a limit minus hysteresis cannot wrap
  always_comb begin
    t14 = {thermal_unit[TSC_TEMP_W-1], thermal_unit};
    hi14 = {upper_alarm_threshold[12], upper_alarm_threshold[12:0]};
    lo14 = {lower_alarm_threshold[12], lower_alarm_threshold[12:0]};
    cr14 = {critical_threshold[12], critical_threshold[12:0]};
    // Trip releases only past the hysteresis band
    if (hi_trip) begin
      next_hi = t14 > (hi14 - $signed(hysteresis_select_steps));
    end else begin
      next_hi = t14 > hi14;
    end
    if (lo_trip) begin
      next_lo = t14 < (lo14 + $signed(hysteresis_select_steps));
    end else begin
      next_lo = t14 < lo14;
    end
    if (crit_trip) begin
      next_crit = t14 > (cr14 - $signed(hysteresis_select_steps));
    end else begin
      next_crit = t14 > cr14;
    end
    crossing = ((next_hi != hi_trip) | (next_lo != lo_trip)) & ~critical_only_select;
  end

  // Trips re-evaluated every cycle unless halted, limits included
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_trip <= 1'b0;
      lo_trip <= 1'b0;
      crit_trip <= 1'b0;
    end else if (!sensor_halt) begin
      hi_trip <= next_hi;
      lo_trip <= next_lo;
      crit_trip <= next_crit;
    end
  end

  // Interrupt latch; a new crossing wins over a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_latch <= 1'b0;
      clear_pending <= 1'b0;
    end else if (sensor_halt && SENSOR_HALT_CLEARS_ALERT) begin
      event_latch <= 1'b0;
      clear_pending <= 1'b0;
    end else if (!int_mode) begin
      event_latch <= 1'b0;
      clear_pending <= 1'b0;
    end else if (!sensor_halt && crossing) begin
      event_latch <= 1'b1;
      clear_pending <= 1'b0;
    end else if (clear_req || clear_pending) begin
      if (crit_trip) begin
        clear_pending <= 1'b1;
      end else begin
        event_latch <= 1'b0;
        clear_pending <= 1'b0;
      end
    end
  end

  always_comb begin
    if (critical_only_select) begin
      next_event = crit_trip;
    end else if (int_mode) begin
      next_event = event_latch | crit_trip;
    end else begin
      next_event = hi_trip | lo_trip | crit_trip;
    end
    if (sensor_halt && SENSOR_HALT_CLEARS_ALERT) begin
      next_event = 1'b0;
    end
    next_status = next_event & out_en;
  end

  // Without the flag, halt lets the alert drop but never rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_active <= 1'b0;
    end else if (!sensor_halt || SENSOR_HALT_CLEARS_ALERT || !next_event) begin
      event_active <= next_event;
    end
  end

  // Disabled pin sits at its inactive level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alert_pin_status <= 1'b0;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert_pin_status <= event_active & out_en;
      alert_out <= 1'b0;
      // Active low pulls down, active high releases
      alert_oe <= alert_polarity ? ~(event_active & out_en) : (event_active & out_en);
    end
  end

  always_comb begin
    feature_flags = '0;
    feature_flags[7] = SENSOR_HALT_CLEARS_ALERT;
    feature_flags[6] = BUS_TIMEOUT_SUPPORTED;
    feature_flags[5] = FEATURE_BIT5;
    feature_flags[4:3] = RESOLUTION_CODE;
    feature_flags[2] = NEGATIVE_SUPPORTED;
    feature_flags[1] = ACCURACY_CLASS;
    feature_flags[0] = INTERRUPT_SUPPORTED;
    ctrl_read = '0;
    ctrl_read[TSC_CTL_HYSTERESIS_SELECT_HI:TSC_CTL_HYSTERESIS_SELECT_LO] = hysteresis_select;
    ctrl_read[TSC_CTL_HALT] = sensor_halt;
    ctrl_read[TSC_CTL_CRIT_LOCK] = crit_limit_write_lock;
    ctrl_read[TSC_CTL_ALARM_LOCK] = alarm_lock;
    ctrl_read[TSC_CTL_CLEAR] = 1'b0;
    ctrl_read[TSC_CTL_STATUS] = alert_pin_status;
    ctrl_read[TSC_CTL_OUT_EN] = out_en;
    ctrl_read[TSC_CTL_CRIT_ONLY] = critical_only_select;
    ctrl_read[TSC_CTL_POL] = alert_polarity;
    ctrl_read[TSC_CTL_MODE] = int_mode;
  end

  // Read data chosen when the access is taken
  always_comb begin
    case (hold.addr)
      TSC_IDX_FEAT: next_rdata = feature_flags;
      TSC_IDX_CTRL: next_rdata = ctrl_read;
      TSC_IDX_HIGH: next_rdata = upper_alarm_threshold;
      TSC_IDX_LOW: next_rdata = lower_alarm_threshold;
      TSC_IDX_CRIT: next_rdata = critical_threshold;
      TSC_IDX_TEMP: next_rdata = {crit_trip, hi_trip, lo_trip, thermal_unit};
      TSC_IDX_MFR: next_rdata = MFR_ID;
      TSC_IDX_DEV: next_rdata = DEV_ID;
      default: next_rdata = '0;
    endcase
  end

endmodule : tsc_ctrl

// >>> verif/tsc_ctrl_asserts.sv
// Concurrent checks on the thermal sensor control ports
`timescale 1ns/1ps
module tsc_ctrl_asserts #(
  parameter logic SENSOR_HALT_CLEARS_ALERT = 1'b0,
  parameter logic BUS_TIMEOUT_SUPPORTED = 1'b1,
  parameter logic FEATURE_BIT5 = 1'b1,
  parameter logic [1:0] RESOLUTION_CODE = tsc_pkg::TSC_RES_0P125,
  parameter logic NEGATIVE_SUPPORTED = 1'b1,
  parameter logic ACCURACY_CLASS = 1'b1,
  parameter logic INTERRUPT_SUPPORTED = 1'b1
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_clk,
  // Register port
  input wire logic lnk_req,
  input wire tsc_pkg::tsc_req_t lnk_cmd,
  input wire logic lnk_busy,
  input wire logic lnk_done,
  input wire logic [15:0] lnk_rdata,
  // Converter and pin
  input wire logic temp_valid,
  input wire logic [tsc_pkg::TSC_TEMP_W-1:0] temp_sample,
  input wire logic conv_run,
  input wire logic alert_out,
  input wire logic alert_oe
);
  import tsc_pkg::*;
  localparam logic [15:0] FEAT = {8'h00, SENSOR_HALT_CLEARS_ALERT, BUS_TIMEOUT_SUPPORTED,
    FEATURE_BIT5, RESOLUTION_CODE, NEGATIVE_SUPPORTED, ACCURACY_CLASS, INTERRUPT_SUPPORTED};
  tsc_req_t held;
  logic take;
  assign take = lnk_req && !lnk_busy;
  // Command in flight, to judge its answer
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      held <= '0;
    end else if (take) begin
      held <= lnk_cmd;
    end
  end
  feat_value_a: assert property (@(posedge link_clk) disable iff (!rstn)
    lnk_done && held.addr == TSC_IDX_FEAT |-> lnk_rdata == FEAT) else $error("feature value");
  ctrl_reserved_zero_a: assert property (@(posedge link_clk) disable iff (!rstn)
    lnk_done && held.addr == TSC_IDX_CTRL |-> lnk_rdata[15:11] == 5'h00 && !lnk_rdata[5])
    else $error("control reserved bits");
  limit_unused_zero_a: assert property (@(posedge link_clk) disable iff (!rstn)
    lnk_done && (held.addr == TSC_IDX_HIGH || held.addr == TSC_IDX_LOW)
    |-> (lnk_rdata & ~TSC_LIMIT_MASK) == 16'h0000) else $error("limit unused bits");
  take_sets_busy_a: assert property (@(posedge link_clk) disable iff (!rstn)
    take |=> lnk_busy) else $error("busy after take");
  access_completes_a: assert property (@(posedge link_clk) disable iff (!rstn)
    take |-> ##[2:40] lnk_done) else $error("access not completed");
  done_pulse_a: assert property (@(posedge link_clk) disable iff (!rstn)
    lnk_done |=> !lnk_done) else $error("done longer than one cycle");
  done_idle_a: assert property (@(posedge link_clk) disable iff (!rstn)
    lnk_done |-> !lnk_busy && $past(lnk_busy)) else $error("done without busy");
  pin_data_low_a: assert property (@(posedge clk) disable iff (!rstn)
    !alert_out) else $error("pin data not low");
endmodule : tsc_ctrl_asserts
bind tsc_ctrl tsc_ctrl_asserts #(.SENSOR_HALT_CLEARS_ALERT(SENSOR_HALT_CLEARS_ALERT),
  .BUS_TIMEOUT_SUPPORTED(BUS_TIMEOUT_SUPPORTED), .FEATURE_BIT5(FEATURE_BIT5),
  .RESOLUTION_CODE(RESOLUTION_CODE), .NEGATIVE_SUPPORTED(NEGATIVE_SUPPORTED),
  .ACCURACY_CLASS(ACCURACY_CLASS), .INTERRUPT_SUPPORTED(INTERRUPT_SUPPORTED)) u_chk (
  .clk(clk), .rstn(rstn), .link_clk(link_clk), .lnk_req(lnk_req), .lnk_cmd(lnk_cmd),
  .lnk_busy(lnk_busy), .lnk_done(lnk_done), .lnk_rdata(lnk_rdata),
  .temp_valid(temp_valid), .temp_sample(temp_sample), .conv_run(conv_run),
  .alert_out(alert_out), .alert_oe(alert_oe));

// >>> verif/tsc_host_model.sv
// Serial engine model issuing register accesses on the link side
`timescale 1ns/1ps
module tsc_host_model (
  // Link side
  input wire logic link_clk,
  output logic lnk_req,
  output tsc_pkg::tsc_req_t lnk_cmd,
  input wire logic lnk_busy,
  input wire logic lnk_done,
  input wire logic [15:0] lnk_rdata
);
  import tsc_pkg::*;
  initial begin
    lnk_req = 1'b0;
    lnk_cmd = '0;
  end
  // Single-cycle request: a held one would be taken again once busy drops
  task automatic access(input logic w, input logic [2:0] a, input logic [15:0] d,
                        output logic [15:0] r);
    int n;
    r = 16'hxxxx;
    // Driven on the falling edge, taken on the next rising edge
    @(negedge link_clk);
    lnk_req = 1'b1;
    lnk_cmd = '{wr: w, addr: a, wdata: d};
    @(negedge link_clk);
    lnk_req = 1'b0;
    // Released lines show no stale value
    lnk_cmd = ~lnk_cmd;
    for (n = 0; n < 100; n++) begin
      @(negedge link_clk);
      if (lnk_done === 1'b1) begin
        r = lnk_rdata;
        break;
      end
    end
  endtask : access
endmodule : tsc_host_model

// >>> verif/tsc_ctrl_tb.sv
// Self-checking bench for the thermal sensor control block
`timescale 1ns/1ps
module tsc_ctrl_tb;
  import tsc_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic temp_valid = 1'b0;
  logic [TSC_TEMP_W-1:0] temp_sample = '0;
  logic lnk_req, lnk_busy, lnk_done, conv_run, alert_out, alert_oe;
  tsc_req_t lnk_cmd;
  logic [15:0] lnk_rdata;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  always #3 link_clk = ~link_clk;
  tsc_ctrl dut (.clk(clk), .rstn(rstn), .link_clk(link_clk), .lnk_req(lnk_req),
    .lnk_cmd(lnk_cmd), .lnk_busy(lnk_busy), .lnk_done(lnk_done), .lnk_rdata(lnk_rdata),
    .temp_valid(temp_valid), .temp_sample(temp_sample), .conv_run(conv_run),
    .alert_out(alert_out), .alert_oe(alert_oe));
  tsc_host_model host (.link_clk(link_clk), .lnk_req(lnk_req), .lnk_cmd(lnk_cmd),
    .lnk_busy(lnk_busy), .lnk_done(lnk_done), .lnk_rdata(lnk_rdata));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    logic [15:0] r;
    host.access(1'b1, a, d, r);
    chk("write done", 16'h0000, {15'h0000, $isunknown(r)});
  endtask : wr
  task automatic rd(input string what, input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] r;
    host.access(1'b0, a, 16'h0000, r);
    chk(what, exp, r);
  endtask : rd
  task automatic sample(input logic [TSC_TEMP_W-1:0] t);
    @(negedge clk);
    temp_sample = t;
    temp_valid = 1'b1;
    @(negedge clk);
    temp_valid = 1'b0;
  endtask : sample
  // Pin is pulled low when alert_oe is high
  task automatic pin(input string what, input logic exp);
    repeat (4) @(negedge clk);
    chk(what, {15'h0000, exp}, {15'h0000, alert_oe});
  endtask : pin
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // Whole run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    rd("feature", TSC_IDX_FEAT, 16'h0077);
    rd("control reset", TSC_IDX_CTRL, 16'h0000);
    rd("high reset", TSC_IDX_HIGH, 16'h0000);
    rd("low reset", TSC_IDX_LOW, 16'h0000);
    wr(TSC_IDX_FEAT, 16'hffff);
    rd("feature read only", TSC_IDX_FEAT, 16'h0077);
    wr(TSC_IDX_CTRL, 16'hff27);
    rd("control fields", TSC_IDX_CTRL, 16'h0707);
    chk("halted", 16'h0000, {15'h0000, conv_run});
    wr(TSC_IDX_CTRL, 16'h0000);
    chk("running", 16'h0001, {15'h0000, conv_run});
    wr(TSC_IDX_HIGH, 16'hffff);
    rd("high masked", TSC_IDX_HIGH, 16'h1ffc);
    wr(TSC_IDX_LOW, 16'h0190);
    rd("low value", TSC_IDX_LOW, 16'h0190);
    wr(TSC_IDX_HIGH, 16'h0320);
    wr(TSC_IDX_CRIT, 16'h0500);
    sample(13'h0200);
    wr(TSC_IDX_CTRL, 16'h0008);
    pin("inside window", 1'b0);
    sample(13'h0340);
    pin("above high", 1'b1);
    rd("status low pol", TSC_IDX_CTRL, 16'h0018);
    wr(TSC_IDX_CTRL, 16'h000a);
    pin("active high", 1'b0);
    rd("status high pol", TSC_IDX_CTRL, 16'h001a);
    wr(TSC_IDX_CTRL, 16'h0002);
    pin("off active high", 1'b1);
    rd("status gated", TSC_IDX_CTRL, 16'h0002);
    wr(TSC_IDX_CTRL, 16'h0000);
    pin("off active low", 1'b0);
    wr(TSC_IDX_CTRL, 16'h0608);
    pin("hysteresis_select trip", 1'b1);
    sample(13'h0318);
    pin("within hysteresis_select", 1'b1);
    sample(13'h02b0);
    pin("below hysteresis_select", 1'b0);
    wr(TSC_IDX_HIGH, 16'h0280);
    pin("limit lowered", 1'b1);
    wr(TSC_IDX_HIGH, 16'h0320);
    pin("limit raised", 1'b0);
    wr(TSC_IDX_CTRL, 16'h0009);
    wr(TSC_IDX_CTRL, 16'h0029);
    pin("int idle", 1'b0);
    sample(13'h0340);
    pin("int event", 1'b1);
    sample(13'h0200);
    pin("int latched", 1'b1);
    wr(TSC_IDX_CTRL, 16'h0029);
    pin("int cleared", 1'b0);
    rd("clear reads zero", TSC_IDX_CTRL, 16'h0009);
    sample(13'h0520);
    wr(TSC_IDX_CTRL, 16'h0029);
    pin("clear above crit", 1'b1);
    sample(13'h0400);
    pin("clear deferred", 1'b0);
    sample(13'h0200);
    wr(TSC_IDX_CTRL, 16'h0028);
    pin("comparator again", 1'b0);
    wr(TSC_IDX_CTRL, 16'h0009);
    sample(13'h0340);
    wr(TSC_IDX_CTRL, 16'h0109);
    pin("halt keeps alert", 1'b1);
    rd("halt frozen status", TSC_IDX_CTRL, 16'h0119);
    sample(13'h0200);
    rd("reading frozen", TSC_IDX_TEMP, 16'h4340);
    wr(TSC_IDX_CTRL, 16'h0129);
    pin("halt clear", 1'b0);
    rd("halt clear status", TSC_IDX_CTRL, 16'h0109);
    wr(TSC_IDX_CTRL, 16'h0008);
    sample(13'h0200);
    rd("reading resumed", TSC_IDX_TEMP, 16'h0200);
    wr(TSC_IDX_CTRL, 16'h0048);
    rd("alarm lock", TSC_IDX_CTRL, 16'h0048);
    wr(TSC_IDX_HIGH, 16'h0100);
    rd("high locked", TSC_IDX_HIGH, 16'h0320);
    wr(TSC_IDX_CTRL, 16'h0707);
    rd("fields locked", TSC_IDX_CTRL, 16'h0048);
    chk("no halt", 16'h0001, {15'h0000, conv_run});
    wr(TSC_IDX_CTRL, 16'h00c8);
    wr(TSC_IDX_CRIT, 16'h0100);
    rd("crit locked", TSC_IDX_CRIT, 16'h0500);
    rd("locks kept", TSC_IDX_CTRL, 16'h00c8);
    end_of_test();
  end
endmodule : tsc_ctrl_tb
